// ===== core/ucpc_pkg.sv
// package: register map, field layouts and types of the cell port configuration block
package ucpc_pkg;
    // register addresses and reset values
    localparam logic [15:0] ADDR_CFG = 16'h4000;
    localparam logic [15:0] ADDR_LUB = 16'h4002;
    localparam logic [15:0] CFG_RESET = 16'h0004;
    localparam logic [15:0] LUB_RESET = 16'h0000;
    localparam logic [15:0] LUB_MASK = 16'h03FF;
    localparam logic [15:0] READ_UNMAPPED = 16'h0000;
    // lookup bit count fields
    localparam int LUB_M_LO = 0;
    localparam int LUB_N_LO = 4;
    localparam int LUB_PAUSE_BIT = 9;
    localparam logic [3:0] VPI_BITS_MAX = 4'hC;
    localparam logic [4:0] VCI_BITS_MAX = 5'h10;
    // highest valid own address
    localparam logic [4:0] ADDR_MAX = 5'h1E;
    // header classification
    localparam logic [11:0] GFC_EXCL_MASK = 12'h0FF;
    localparam logic [15:0] VCI_F4_SEG = 16'h0003;
    localparam logic [15:0] VCI_F4_E2E = 16'h0004;
    localparam logic [1:0] PTI_OAM = 2'h2;
    // timing
    localparam int CLK_MHZ = 50;
    localparam int PAUSE_NS = 40;
    localparam int PAUSE_CYC = (PAUSE_NS * CLK_MHZ + 999) / 1000;
    localparam logic [1:0] PAUSE_LOAD = 2'(PAUSE_CYC - 1);

    // configuration register, bit 15 down to bit 0
    typedef struct packed {
        logic configured;
        logic [4:0] dev_addr;
        logic phy_end;
        logic tx_drv;
        logic clav_drv;
        logic keep_unknown;
        logic level1;
        logic eight_bit;
        logic keep_oam;
        logic clk_ext;
        logic uni;
        logic structured;
    } ucpc_cfg_t;

    // received cell header fields
    typedef struct packed {
        logic [3:0] gfc;
        logic [7:0] vpi;
        logic [15:0] vci;
        logic [2:0] pti;
        logic clp;
    } ucpc_hdr_t;

    // unstructured match values and enables
    typedef struct packed {
        logic [11:0] vp_val;
        logic [11:0] vp_enb;
        logic [15:0] vc_val;
        logic [15:0] vc_enb;
    } ucpc_match_t;

    typedef enum logic [1:0] {
        PS_RUN = 2'b01,
        PS_PAUSE = 2'b10
    } ucpc_pause_t;
endpackage

// ===== core/ucpc_port_clock.sv
// one port clock pin: internal divider or synchronised external edge detect
`timescale 1ns/100ps
module ucpc_port_clock
    import ucpc_pkg::*;
(
    // system
    input wire logic clk,
    input wire logic reset,
    // control
    input wire logic drive_en,
    // pin
    input wire logic pin_in,
    output logic pin_out,
    output logic pin_oe,
    // edge of the port clock
    output logic rise
);
    logic s1_r, s2_r, s3_r, div_r, oe_r, rise_r;
    logic s3_nxt, div_nxt, oe_nxt, rise_nxt;

    // divider toggles every clock; external pin passes two flops first
    always_comb begin
        s3_nxt = s2_r;
        div_nxt = drive_en ? ~div_r : 1'b0;
        oe_nxt = drive_en;
        rise_nxt = drive_en ? (div_nxt & ~div_r) : (s2_r & ~s3_r);
    end

    always_ff @(posedge clk) begin
        if (reset) begin
            s1_r <= 1'b0;
            s2_r <= 1'b0;
            s3_r <= 1'b0;
            div_r <= 1'b0;
            oe_r <= 1'b0;
            rise_r <= 1'b0;
        end else begin
            s1_r <= pin_in;
            s2_r <= s1_r;
            s3_r <= s3_nxt;
            div_r <= div_nxt;
            oe_r <= oe_nxt;
            rise_r <= rise_nxt;
        end
    end

    assign pin_out = div_r;
    assign pin_oe = oe_r;
    assign rise = rise_r;

    property p_clk_half;
        @(posedge clk) disable iff (reset) drive_en ##1 drive_en |-> pin_oe && pin_out != $past(pin_out);
    endproperty
    a_clk_half: assert property (p_clk_half) else $error("internal port clock not at half rate");

    property p_clk_input;
        @(posedge clk) disable iff (reset) !drive_en |=> !pin_oe && !pin_out;
    endproperty
    a_clk_input: assert property (p_clk_input) else $error("port clock pin driven while external");
endmodule

// ===== core/ucpc_top.sv
// cell port configuration registers, receive cell filter and pin control
`timescale 1ns/100ps
module ucpc_top
    import ucpc_pkg::*;
(
    // system
    input wire logic clk,
    input wire logic reset,
    // microprocessor port
    input wire logic cpu_cs,
    input wire logic cpu_wr,
    input wire logic [15:0] cpu_addr,
    input wire logic [15:0] cpu_wdata,
    output logic [15:0] cpu_rdata,
    // port clock pins
    input wire logic receive_port_clock_in,
    output logic receive_port_clock_out,
    output logic receive_port_clock_oe,
    input wire logic transmit_port_clock_in,
    output logic transmit_port_clock_out,
    output logic transmit_port_clock_oe,
    // address buses and handshake pins
    input wire logic [4:0] receive_address_bus,
    input wire logic [4:0] transmit_address_bus,
    output logic receive_enable_cell_avail,
    output logic receive_enable_cell_avail_oe,
    output logic transmit_enable_cell_avail,
    output logic transmit_enable_cell_avail_oe,
    output logic transmit_data_oe,
    // cell engine handshake levels
    input wire logic rx_clav_in,
    input wire logic tx_clav_in,
    input wire logic rx_enb_n_in,
    input wire logic tx_enb_n_in,
    input wire logic tx_active,
    input wire logic rx_cell_end,
    // header filter
    input wire logic hdr_valid,
    input wire ucpc_hdr_t hdr,
    input wire ucpc_match_t match,
    input wire logic lut_done,
    input wire logic lut_unknown,
    output logic verdict_valid,
    output logic verdict_keep,
    output logic verdict_lookup,
    output logic [15:0] lut_addr,
    // effective mode to the cell engine
    output ucpc_cfg_t port_mode
);
    ucpc_cfg_t cfg_r, cfg_nxt, eff_r, eff_nxt;
    logic [15:0] lub_r, lub_nxt, rdata_r, rdata_nxt;
    logic [4:0] rxa1_r, rxa2_r, txa1_r, txa2_r;
    logic rx_poll_r, rx_poll_nxt, tx_poll_r, tx_poll_nxt;
    logic rx_pin_r, rx_pin_nxt, rx_oe_r, rx_oe_nxt;
    logic tx_pin_r, tx_pin_nxt, tx_oe_r, tx_oe_nxt, txd_oe_r, txd_oe_nxt;
    logic vv_r, vv_nxt, vk_r, vk_nxt, vl_r, vl_nxt;
    logic [15:0] la_r, la_nxt;
    ucpc_pause_t ps_r, ps_nxt;
    logic [1:0] pcnt_r, pcnt_nxt;
    logic rx_rise, tx_rise, pause_en, multi_phy_operation, addr_ok;
    logic [11:0] vp_full;

    // a header is OAM by F5 payload type or F4 reserved channel
    function automatic logic is_oam(input ucpc_hdr_t h);
        is_oam = (h.pti[2:1] == PTI_OAM) || (h.vci == VCI_F4_SEG) || (h.vci == VCI_F4_E2E);
    endfunction

    // lookup index: low m VPI bits above low n VCI bits, counts capped
    function automatic logic [15:0] lut_index(input logic [11:0] vp, input logic [15:0] vc,
                                              input logic [3:0] m, input logic [4:0] n);
        logic [3:0] mc;
        logic [4:0] nc;
        logic [31:0] vp_part;
        logic [31:0] vc_part;
        mc = (m > VPI_BITS_MAX) ? VPI_BITS_MAX : m;
        nc = (n > VCI_BITS_MAX) ? VCI_BITS_MAX : n;
        vc_part = {16'h0000, vc} & ((32'h0000_0001 << nc) - 32'h0000_0001);
        vp_part = ({20'h00000, vp} & ((32'h0000_0001 << mc) - 32'h0000_0001)) << nc;
        lut_index = 16'(vp_part | vc_part);
    endfunction

    // port clock pins, one divider or edge detector each
    ucpc_port_clock u_rx_clk (
        .clk(clk),
        .reset(reset),
        .drive_en(!eff_r.clk_ext),
        .pin_in(receive_port_clock_in),
        .pin_out(receive_port_clock_out),
        .pin_oe(receive_port_clock_oe),
        .rise(rx_rise)
    );
    ucpc_port_clock u_tx_clk (
        .clk(clk),
        .reset(reset),
        .drive_en(!eff_r.clk_ext),
        .pin_in(transmit_port_clock_in),
        .pin_out(transmit_port_clock_out),
        .pin_oe(transmit_port_clock_oe),
        .rise(tx_rise)
    );

    // register writes, reads and the effective copy
    always_comb begin
        cfg_nxt = cfg_r;
        lub_nxt = lub_r;
        rdata_nxt = rdata_r;
        eff_nxt = cfg_r.configured ? cfg_r : ucpc_cfg_t'(CFG_RESET);
        if (cpu_cs && cpu_wr && cpu_addr == ADDR_CFG) begin
            cfg_nxt = ucpc_cfg_t'(cpu_wdata);
        end
        if (cpu_cs && cpu_wr && cpu_addr == ADDR_LUB) begin
            lub_nxt = cpu_wdata & LUB_MASK;
        end
        if (cpu_cs && !cpu_wr) begin
            case (cpu_addr)
                ADDR_CFG: rdata_nxt = cfg_r;
                ADDR_LUB: rdata_nxt = lub_r;
                default: rdata_nxt = READ_UNMAPPED;
            endcase
        end
    end

    always_ff @(posedge clk) begin
        if (reset) begin
            cfg_r <= ucpc_cfg_t'(CFG_RESET);
            lub_r <= LUB_RESET;
            rdata_r <= READ_UNMAPPED;
            eff_r <= ucpc_cfg_t'(CFG_RESET);
        end else begin
            cfg_r <= cfg_nxt;
            lub_r <= lub_nxt;
            rdata_r <= rdata_nxt;
            eff_r <= eff_nxt;
        end
    end

    // width, level and role go to the cell engine unchanged
    assign port_mode = eff_r;
    assign cpu_rdata = rdata_r;
    assign pause_en = lub_r[LUB_PAUSE_BIT] && eff_r.configured;
    assign multi_phy_operation = !eff_r.level1;
    assign addr_ok = eff_r.dev_addr <= ADDR_MAX;

    // per-cell pause state machine for the ATM-end receiver
    always_comb begin
        ps_nxt = ps_r;
        pcnt_nxt = pcnt_r;
        case (ps_r)
            PS_RUN: begin
                if (rx_cell_end && pause_en && !eff_r.phy_end) begin
                    ps_nxt = PS_PAUSE;
                    pcnt_nxt = PAUSE_LOAD;
                end
            end
            PS_PAUSE: begin
                if (pcnt_r == 2'h0) begin
                    ps_nxt = PS_RUN;
                end else begin
                    pcnt_nxt = pcnt_r - 2'h1;
                end
            end
            default: begin
                ps_nxt = PS_RUN;
                pcnt_nxt = 2'h0;
            end
        endcase
    end

    always_ff @(posedge clk) begin
        if (reset) begin
            ps_r <= PS_RUN;
            pcnt_r <= 2'h0;
        end else begin
            ps_r <= ps_nxt;
            pcnt_r <= pcnt_nxt;
        end
    end

    // polling, handshake pins and output enables
    always_comb begin
        rx_poll_nxt = rx_poll_r;
        tx_poll_nxt = tx_poll_r;
        if (rx_rise) begin
            rx_poll_nxt = addr_ok && (rxa2_r == eff_r.dev_addr);
        end
        if (tx_rise) begin
            tx_poll_nxt = addr_ok && (txa2_r == eff_r.dev_addr);
        end
        if (eff_r.phy_end) begin
            rx_pin_nxt = rx_clav_in;
            tx_pin_nxt = tx_clav_in;
            rx_oe_nxt = eff_r.configured && (eff_r.clav_drv || !multi_phy_operation || rx_poll_nxt);
            tx_oe_nxt = eff_r.configured && (eff_r.clav_drv || !multi_phy_operation || tx_poll_nxt);
        end else begin
            rx_pin_nxt = (ps_nxt == PS_PAUSE) ? 1'b1 : rx_enb_n_in;
            tx_pin_nxt = tx_enb_n_in;
            rx_oe_nxt = eff_r.configured;
            tx_oe_nxt = eff_r.configured;
        end
        txd_oe_nxt = eff_r.configured && (eff_r.tx_drv || tx_active);
    end

    always_ff @(posedge clk) begin
        if (reset) begin
            rxa1_r <= 5'h00;
            rxa2_r <= 5'h00;
            txa1_r <= 5'h00;
            txa2_r <= 5'h00;
            rx_poll_r <= 1'b0;
            tx_poll_r <= 1'b0;
            rx_pin_r <= 1'b1;
            tx_pin_r <= 1'b1;
            rx_oe_r <= 1'b0;
            tx_oe_r <= 1'b0;
            txd_oe_r <= 1'b0;
        end else begin
            rxa1_r <= receive_address_bus;
            rxa2_r <= rxa1_r;
            txa1_r <= transmit_address_bus;
            txa2_r <= txa1_r;
            rx_poll_r <= rx_poll_nxt;
            tx_poll_r <= tx_poll_nxt;
            rx_pin_r <= rx_pin_nxt;
            tx_pin_r <= tx_pin_nxt;
            rx_oe_r <= rx_oe_nxt;
            tx_oe_r <= tx_oe_nxt;
            txd_oe_r <= txd_oe_nxt;
        end
    end

    assign receive_enable_cell_avail = rx_pin_r;
    assign receive_enable_cell_avail_oe = rx_oe_r;
    assign transmit_enable_cell_avail = tx_pin_r;
    assign transmit_enable_cell_avail_oe = tx_oe_r;
    assign transmit_data_oe = txd_oe_r;

    // header filter: OAM, unstructured match, lookup and unknown route
    assign vp_full = {hdr.gfc, hdr.vpi};
    always_comb begin
        logic [11:0] vp_mask;
        logic hit;
        vp_mask = match.vp_enb & (eff_r.uni ? GFC_EXCL_MASK : 12'hFFF);
        hit = (((vp_full ^ match.vp_val) & vp_mask) == 12'h000)
            && (((hdr.vci ^ match.vc_val) & match.vc_enb) == 16'h0000);
        vv_nxt = 1'b0;
        vk_nxt = vk_r;
        vl_nxt = vl_r;
        la_nxt = la_r;
        if (hdr_valid && eff_r.configured) begin
            vv_nxt = 1'b1;
            la_nxt = lut_index(vp_full, hdr.vci, lub_r[LUB_M_LO +: 4], lub_r[LUB_N_LO +: 5]);
            if (is_oam(hdr) && !eff_r.keep_oam) begin
                vk_nxt = 1'b0;
                vl_nxt = 1'b0;
            end else if (eff_r.structured) begin
                vk_nxt = 1'b0;
                vl_nxt = 1'b1;
            end else begin
                vk_nxt = hit;
                vl_nxt = !hit;
            end
        end else if (lut_done && eff_r.configured) begin
            vv_nxt = 1'b1;
            vl_nxt = 1'b0;
            vk_nxt = lut_unknown ? eff_r.keep_unknown : 1'b1;
        end
    end

    always_ff @(posedge clk) begin
        if (reset) begin
            vv_r <= 1'b0;
            vk_r <= 1'b0;
            vl_r <= 1'b0;
            la_r <= 16'h0000;
        end else begin
            vv_r <= vv_nxt;
            vk_r <= vk_nxt;
            vl_r <= vl_nxt;
            la_r <= la_nxt;
        end
    end

    assign verdict_valid = vv_r;
    assign verdict_keep = vk_r;
    assign verdict_lookup = vl_r;
    assign lut_addr = la_r;

    // checks
    sequence s_cell_end;
        rx_cell_end && pause_en && !eff_r.phy_end && ps_r == PS_RUN;
    endsequence
    sequence s_oam_drop;
        hdr_valid && eff_r.configured && is_oam(hdr) && !eff_r.keep_oam;
    endsequence

    property p_cfg_reset;
        @(posedge clk) disable iff (reset) $fell(reset) |-> cfg_r == CFG_RESET && eff_r.clk_ext;
    endproperty
    a_cfg_reset: assert property (p_cfg_reset) else $error("config reset value wrong");

    property p_lub_reset;
        @(posedge clk) disable iff (reset) $fell(reset) |-> lub_r == LUB_RESET;
    endproperty
    a_lub_reset: assert property (p_lub_reset) else $error("lookup count reset value wrong");

    property p_lub_rsvd;
        @(posedge clk) disable iff (reset)
            cpu_cs && cpu_wr && cpu_addr == ADDR_LUB |=> lub_r == ($past(cpu_wdata) & LUB_MASK);
    endproperty
    a_lub_rsvd: assert property (p_lub_rsvd) else $error("reserved lookup bits stored");

    property p_idle;
        @(posedge clk) disable iff (reset) !cfg_r.configured |=> eff_r == CFG_RESET;
    endproperty
    a_idle: assert property (p_idle) else $error("config applied before configured");

    property p_oam;
        @(posedge clk) disable iff (reset) s_oam_drop |=> verdict_valid && !verdict_keep && !verdict_lookup;
    endproperty
    a_oam: assert property (p_oam) else $error("OAM cell not dropped");

    property p_struct;
        @(posedge clk) disable iff (reset)
            hdr_valid && eff_r.configured && eff_r.structured && !is_oam(hdr) |=> verdict_lookup && !verdict_keep;
    endproperty
    a_struct: assert property (p_struct) else $error("structured cell skipped lookup");

    property p_unknown;
        @(posedge clk) disable iff (reset)
            !hdr_valid && lut_done && lut_unknown && eff_r.configured |=> verdict_valid
            && verdict_keep == $past(eff_r.keep_unknown);
    endproperty
    a_unknown: assert property (p_unknown) else $error("unknown cell handling wrong");

    property p_pause;
        @(posedge clk) disable iff (reset) s_cell_end |=> receive_enable_cell_avail [*2];
    endproperty
    a_pause: assert property (p_pause) else $error("receive pause too short");

    property p_clav_float;
        @(posedge clk) disable iff (reset)
            eff_r.phy_end && multi_phy_operation && !eff_r.clav_drv && !rx_poll_nxt |=> !receive_enable_cell_avail_oe;
    endproperty
    a_clav_float: assert property (p_clav_float) else $error("cell available driven unpolled");

    property p_tx_drive;
        @(posedge clk) disable iff (reset) eff_r.configured && eff_r.tx_drv |=> transmit_data_oe;
    endproperty
    a_tx_drive: assert property (p_tx_drive) else $error("transmit outputs not driven");
endmodule

// ===== tb/ucpc_far_model.sv
// far-side cell bus device: free-running port clock and address polling
`timescale 1ns/100ps
module ucpc_far_model
    import ucpc_pkg::*;
(
    // control from the bench
    input wire logic run,
    input wire logic [4:0] poll_addr,
    // pins
    output logic port_clk,
    output logic [4:0] rx_addr,
    output logic [4:0] tx_addr
);
    // 160 ns link clock, addresses change on its falling edge
    initial begin
        port_clk = 1'b0;
        rx_addr = 5'h1F;
        tx_addr = 5'h1F;
        #7;
        forever begin
            #80;
            port_clk = run & ~port_clk;
            if (!port_clk) begin
                rx_addr = poll_addr;
                tx_addr = poll_addr;
            end
        end
    end
endmodule

// ===== tb/ucpc_top_tb.sv
// self-checking bench of the cell port configuration block
`timescale 1ns/100ps
module ucpc_top_tb
    import ucpc_pkg::*;
;
    logic clk, reset, cpu_cs, cpu_wr, rx_out, rx_oe, tx_out, tx_oe, far_clk, far_run;
    logic rxe, rxe_oe, txe, txe_oe, tdata_oe, rx_clav_in, tx_clav_in, rx_enb_n_in, tx_enb_n_in;
    logic tx_active, rx_cell_end, hdr_valid, lut_done, lut_unknown, vv, vk, vl, p;
    logic [15:0] cpu_addr, cpu_wdata, cpu_rdata, lut_addr, v;
    logic [4:0] rx_ab, tx_ab, poll;
    logic [18:0] e;
    logic [18:0] exp_q[$];
    ucpc_hdr_t hdr, h, h0;
    ucpc_match_t match;
    ucpc_cfg_t port_mode;
    int error_cnt, comparisons, cyc, seed, n, k;
    wire rx_pin = rx_oe ? rx_out : far_clk;
    wire tx_pin = tx_oe ? tx_out : far_clk;

    ucpc_far_model far (.run(far_run), .poll_addr(poll), .port_clk(far_clk), .rx_addr(rx_ab), .tx_addr(tx_ab));

    ucpc_top dut (.clk(clk), .reset(reset), .cpu_cs(cpu_cs), .cpu_wr(cpu_wr), .cpu_addr(cpu_addr),
        .cpu_wdata(cpu_wdata), .cpu_rdata(cpu_rdata), .receive_port_clock_in(rx_pin),
        .receive_port_clock_out(rx_out), .receive_port_clock_oe(rx_oe), .transmit_port_clock_in(tx_pin),
        .transmit_port_clock_out(tx_out), .transmit_port_clock_oe(tx_oe), .receive_address_bus(rx_ab),
        .transmit_address_bus(tx_ab), .receive_enable_cell_avail(rxe), .receive_enable_cell_avail_oe(rxe_oe),
        .transmit_enable_cell_avail(txe), .transmit_enable_cell_avail_oe(txe_oe),
        .transmit_data_oe(tdata_oe), .rx_clav_in(rx_clav_in), .tx_clav_in(tx_clav_in),
        .rx_enb_n_in(rx_enb_n_in), .tx_enb_n_in(tx_enb_n_in), .tx_active(tx_active),
        .rx_cell_end(rx_cell_end), .hdr_valid(hdr_valid), .hdr(hdr), .match(match), .lut_done(lut_done),
        .lut_unknown(lut_unknown), .verdict_valid(vv), .verdict_keep(vk), .verdict_lookup(vl),
        .lut_addr(lut_addr), .port_mode(port_mode));

    // clock generation
    initial begin
        clk = 1'b0;
        forever #10 clk = ~clk;
    end

    task automatic chk(input logic [15:0] got, input logic [15:0] exp);
        comparisons++;
        if (got !== exp) begin
            error_cnt++;
            $display("CHECK FAILED t=%0t got=%h exp=%h", $time, got, exp);
        end
    endtask

    task automatic report_and_stop();
        $display("counts: comparisons=%0d mismatches=%0d", comparisons, error_cnt);
        if (error_cnt == 0 && comparisons > 0)
            $display("Run complete: PASS");
        else
            $display("Run complete: FAIL");
        $finish;
    endtask

    // register write, entered and left just after a rising edge
    task automatic wr(input logic [15:0] a, input logic [15:0] d);
        cpu_cs <= 1'b1;
        cpu_wr <= 1'b1;
        cpu_addr <= a;
        cpu_wdata <= d;
        @(posedge clk);
        cpu_cs <= 1'b0;
        @(posedge clk);
    endtask

    // register read, data settled by the next falling edge
    task automatic rd(input logic [15:0] a, input logic [15:0] exp);
        cpu_cs <= 1'b1;
        cpu_wr <= 1'b0;
        cpu_addr <= a;
        @(posedge clk);
        cpu_cs <= 1'b0;
        @(negedge clk);
        chk(cpu_rdata, exp);
        @(posedge clk);
    endtask

    // header or lookup result, expected verdict noted first
    task automatic feed(input logic l, input ucpc_hdr_t hh, input logic u, input logic [18:0] ex, input logic want);
        hdr <= hh;
        lut_unknown <= u;
        hdr_valid <= ~l;
        lut_done <= l;
        if (want)
            exp_q.push_back(ex);
        @(posedge clk);
        hdr_valid <= 1'b0;
        lut_done <= 1'b0;
        @(posedge clk);
    endtask

    // wait bounded time for the receive handshake enable
    task automatic wait_oe(input logic x);
        n = 0;
        while (rxe_oe !== x && n < 60) begin
            @(negedge clk);
            n++;
        end
        chk(16'(rxe_oe), 16'(x));
        @(posedge clk);
    endtask

    // verdict monitor: oldest note against each verdict
    always @(negedge clk) begin
        if (vv === 1'b1) begin
            if (exp_q.size() == 0) begin
                chk(16'h0BAD, 16'h0000);
            end else begin
                e = exp_q.pop_front();
                chk(16'({vk, vl}), 16'(e[17:16]));
                if (e[18])
                    chk(lut_addr, e[15:0]);
            end
        end
    end

    // hang guard
    always @(posedge clk) begin
        cyc++;
        if (cyc == 20000) begin
            error_cnt++;
            report_and_stop();
        end
    end

    initial begin
        seed = 32'h8095;
        {cpu_cs, cpu_wr, cpu_addr, cpu_wdata, rx_clav_in, tx_clav_in, tx_enb_n_in, tx_active} = '0;
        {rx_cell_end, hdr_valid, lut_done, lut_unknown, rx_enb_n_in, poll} = '0;
        far_run = 1'b1;
        h0 = {4'hA, 8'h5C, 16'h1234, 3'h0, 1'b0};
        hdr = h0;
        match = {4'hA, 8'h5C, 12'hFFF, 16'h1234, 16'hFFFF};
        reset = 1'b1;
        repeat (12) @(posedge clk);
        reset <= 1'b0;
        @(posedge clk);
        // reset values, reserved bits, unconfigured port
        rd(ADDR_CFG, 16'h0004);
        rd(ADDR_LUB, 16'h0000);
        rd(16'h4010, READ_UNMAPPED);
        wr(ADDR_LUB, 16'hFC84);
        rd(ADDR_LUB, 16'h0084);
        wr(ADDR_LUB, 16'h0284);
        wr(ADDR_CFG, 16'h03FB);
        chk(port_mode, CFG_RESET);
        feed(1'b0, h0, 1'b0, '0, 1'b0);
        wr(ADDR_CFG, 16'h0004);
        wr(ADDR_CFG, 16'h8004);
        $display("test done: reset and registers");
        // every field reaches the port once configured
        for (k = 0; k < 15; k++) begin
            v = 16'h8004 | (16'h0001 << k);
            wr(ADDR_CFG, v);
            @(negedge clk);
            chk(port_mode, v);
            @(posedge clk);
            rd(ADDR_CFG, v);
        end
        $display("test done: field mapping");
        // receive filter in all modes
        wr(ADDR_CFG, 16'h8004);
        feed(1'b0, h0, 1'b0, {3'b010, 16'h0}, 1'b1);
        h = h0;
        h.gfc = 4'h3;
        feed(1'b0, h, 1'b0, {3'b101, 16'h0C34}, 1'b1);
        feed(1'b0, h0 ^ 32'h8, 1'b0, {3'b000, 16'h0}, 1'b1);
        feed(1'b1, h0, 1'b1, {3'b000, 16'h0}, 1'b1);
        wr(ADDR_CFG, 16'h8006);
        feed(1'b0, h, 1'b0, {3'b010, 16'h0}, 1'b1);
        wr(ADDR_CFG, 16'h804C);
        feed(1'b0, h0 ^ 32'h8, 1'b0, {3'b010, 16'h0}, 1'b1);
        feed(1'b1, h0, 1'b1, {3'b010, 16'h0}, 1'b1);
        feed(1'b1, h0, 1'b0, {3'b010, 16'h0}, 1'b1);
        wr(ADDR_CFG, 16'h8005);
        feed(1'b0, h0, 1'b0, {3'b101, 16'h0C34}, 1'b1);
        for (k = 0; k < 8; k++) begin
            h = $random(seed);
            h.pti = 3'h0;
            h.vci[8] = 1'b1;
            feed(1'b0, h, 1'b0, {3'b101, 4'h0, h.vpi[3:0], h.vci[7:0]}, 1'b1);
        end
        $display("test done: filter");
        // ATM-end pause and transmit drive
        rx_cell_end <= 1'b1;
        @(posedge clk);
        rx_cell_end <= 1'b0;
        n = 0;
        repeat (6) begin
            @(negedge clk);
            n += (rxe === 1'b1);
        end
        chk(16'(n), 16'(PAUSE_CYC));
        chk(16'({rxe, rxe_oe, txe, txe_oe}), 16'h0005);
        @(posedge clk);
        for (k = 0; k < 4; k++) begin
            tx_active <= k[0];
            wr(ADDR_CFG, 16'h8004 | {7'h0, k[1], 8'h0});
            @(posedge clk);
            @(negedge clk);
            chk(16'(tdata_oe), 16'(k[0] | k[1]));
            @(posedge clk);
        end
        $display("test done: pause and drive");
        // PHY-end Level 2 polling on an external port clock
        poll <= 5'h07;
        rx_clav_in <= 1'b1;
        wr(ADDR_CFG, 16'h9604);
        wait_oe(1'b0);
        poll <= 5'h05;
        wait_oe(1'b1);
        @(negedge clk);
        chk(16'({rxe, txe, txe_oe}), 16'h0005);
        poll <= 5'h07;
        wait_oe(1'b0);
        wr(ADDR_CFG, 16'h9684);
        wait_oe(1'b1);
        $display("test done: polling");
        // second reset, then internal port clock
        reset <= 1'b1;
        far_run <= 1'b0;
        repeat (2) @(posedge clk);
        reset <= 1'b0;
        @(posedge clk);
        rd(ADDR_CFG, 16'h0004);
        wr(ADDR_CFG, 16'h0000);
        wr(ADDR_CFG, 16'h8000);
        repeat (4) @(posedge clk);
        @(negedge clk);
        chk(16'({rx_oe, tx_oe}), 16'h0003);
        n = 0;
        p = rx_out;
        repeat (8) begin
            @(negedge clk);
            n += (rx_out !== p);
            p = rx_out;
        end
        chk(16'(n), 16'h0008);
        chk(16'(rx_out ^ tx_out), 16'h0000);
        chk(16'(exp_q.size()), 16'h0000);
        $display("test done: internal clock");
        report_and_stop();
    end
endmodule
